// ### src/fsl_ctl_drive.sv
// Control-pin pattern decoder: drive mode, open drain and tristate handling
`timescale 1ns/1ps
module fsl_ctl_drive (
    input  wire logic [7:0]             pattern,      // Selected pattern register
    input  wire logic [7:0]             drive_config, // Tristate bit and drive types
    output fsl_pkg::fsl_ctl_drive_t     drive         // Pin values and enables
);
    import fsl_pkg::*;

    logic tri_mode;

    assign tri_mode = drive_config[TRISTATE_BIT];

    genvar i;
    generate
        for (i = 0; i < NUM_CTL; i++) begin : g_pin
            if (i < NUM_TRI) begin : g_tri
                always_comb begin
                    if (tri_mode) begin
                        drive.value[i]  = pattern[i];
                        drive.enable[i] = pattern[i + NUM_TRI];
                    end else if (drive_config[i]) begin
                        drive.value[i]  = 1'b0;
                        drive.enable[i] = ~pattern[i];
                    end else begin
                        drive.value[i]  = pattern[i];
                        drive.enable[i] = 1'b1;
                    end
                end
            end else begin : g_wide
                always_comb begin
                    if (tri_mode) begin
                        drive.value[i]  = 1'b0;
                        drive.enable[i] = 1'b0;
                    end else if (drive_config[i]) begin
                        drive.value[i]  = 1'b0;
                        drive.enable[i] = ~pattern[i];
                    end else begin
                        drive.value[i]  = pattern[i];
                        drive.enable[i] = 1'b1;
                    end
                end
            end
        end
    endgenerate
endmodule

// ### src/fsl_flow_logic.sv
// Flow-state logic function, control pattern drive and strobe gating
`timescale 1ns/1ps
module fsl_flow_logic (
    input  wire logic                  CLK_SYS,        // 125 MHz interface clock
    input  wire logic                  RSTN,           // Async reset, active low
    input  fsl_pkg::fsl_axi_req_t      AXI_REQ,        // AXI4-Lite master request
    output fsl_pkg::fsl_axi_rsp_t      AXI_RSP,        // AXI4-Lite slave response
    input  wire logic [2:0]            WAVE_STATE,     // Current waveform state
    input  wire logic                  WAVE_ACTIVE,    // Waveform engine running
    input  wire logic                  WAVE_MASTER,    // Block is bus master
    input  wire logic [5:0]            WAVE_CTL,       // Descriptor control outputs
    input  wire logic [2:0]            STROBE_SELECT,  // Control pin used as strobe
    input  fsl_pkg::fsl_terms_t        TERMS,          // Ready, count and FIFO terms
    input  fsl_pkg::fsl_flag_sel_t     FLAG_SELECT,    // Endpoint flag select
    output logic [5:0]                 CTL_OUT,        // Control pin values
    output logic [5:0]                 CTL_OE,         // Control pin enables
    output logic                       FLOW_ACTIVE,    // In flow state
    output logic                       FLOW_ADVANCE,   // Data may move this cycle
    output logic                       FLOW_RESULT     // Current function result
);
    import fsl_pkg::*;

    // ------------------------------------------------------------
    // Reset synchroniser
    // ------------------------------------------------------------
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    fsl_func_reg_t flow_function_select;
    logic [7:0]    flow_zero_ctl_pattern;
    logic [7:0]    flow_one_ctl_pattern;
    logic [7:0]    flow_state_ctrl;
    logic [7:0]    control_drive_config;
    logic [7:0]    ready_configuration;
    logic [7:0]    strobe_config;

    // ------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------
    logic              aw_held;
    logic              w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              do_write;
    logic              wr_hit;

    assign AXI_RSP.awready = !aw_held && !bvalid;
    assign AXI_RSP.wready  = !w_held && !bvalid;
    assign AXI_RSP.bvalid  = bvalid;
    assign AXI_RSP.bresp   = bresp;
    assign do_write        = aw_held && w_held && !bvalid;

    always_comb begin
        case (aw_addr)
            ADDR_FUNC, ADDR_EQ0, ADDR_EQ1, ADDR_STATE,
            ADDR_DRIVE, ADDR_READY, ADDR_STROBE: wr_hit = 1'b1;
            default:                             wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= '0;
            w_data  <= '0;
            w_strb  <= '0;
            bvalid  <= 1'b0;
            bresp   <= RESP_OKAY;
        end else begin
            if (AXI_REQ.awvalid && AXI_RSP.awready) begin
                aw_held <= 1'b1;
                aw_addr <= AXI_REQ.awaddr;
            end
            if (AXI_REQ.wvalid && AXI_RSP.wready) begin
                w_held <= 1'b1;
                w_data <= AXI_REQ.wdata;
                w_strb <= AXI_REQ.wstrb;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held  <= 1'b0;
                bvalid  <= 1'b1;
                bresp   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid && AXI_REQ.bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            flow_function_select  <= RESET_FUNC;
            flow_zero_ctl_pattern <= RESET_EQ;
            flow_one_ctl_pattern  <= RESET_EQ;
            flow_state_ctrl       <= RESET_STATE;
            control_drive_config  <= RESET_DRIVE;
            ready_configuration   <= RESET_READY;
            strobe_config         <= RESET_STROBE;
        end else if (do_write && w_strb[0]) begin
            case (aw_addr)
                ADDR_FUNC:   flow_function_select  <= w_data[7:0];
                ADDR_EQ0:    flow_zero_ctl_pattern <= w_data[7:0];
                ADDR_EQ1:    flow_one_ctl_pattern  <= w_data[7:0];
                ADDR_STATE:  flow_state_ctrl       <= {w_data[7], 4'h0, w_data[2:0]};
                ADDR_DRIVE:  control_drive_config  <= w_data[7:0];
                ADDR_READY:  ready_configuration   <= w_data[7:0];
                ADDR_STROBE: strobe_config         <= {2'b00, w_data[5], 5'h00};
                default:     flow_state_ctrl       <= flow_state_ctrl;
            endcase
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [7:0]  flow_status;

    assign AXI_RSP.arready = !rvalid;
    assign AXI_RSP.rvalid  = rvalid;
    assign AXI_RSP.rdata   = rdata;
    assign AXI_RSP.rresp   = rresp;

    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            rvalid <= 1'b0;
            rdata  <= '0;
            rresp  <= RESP_OKAY;
        end else if (AXI_REQ.arvalid && !rvalid) begin
            rvalid <= 1'b1;
            rresp  <= RESP_OKAY;
            case (AXI_REQ.araddr)
                ADDR_FUNC:   rdata <= {24'h000000, flow_function_select};
                ADDR_EQ0:    rdata <= {24'h000000, flow_zero_ctl_pattern};
                ADDR_EQ1:    rdata <= {24'h000000, flow_one_ctl_pattern};
                ADDR_STATE:  rdata <= {24'h000000, flow_state_ctrl};
                ADDR_DRIVE:  rdata <= {24'h000000, control_drive_config};
                ADDR_READY:  rdata <= {24'h000000, ready_configuration};
                ADDR_STROBE: rdata <= {24'h000000, strobe_config};
                ADDR_STATUS: rdata <= {24'h000000, flow_status};
                default: begin
                    rdata <= '0;
                    rresp <= RESP_SLVERR;
                end
            endcase
        end else if (rvalid && AXI_REQ.rready) begin
            rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Term selection and logic function
    // ------------------------------------------------------------
    logic [7:0] term_vec;
    logic       fifo_flag;
    logic       term_a;
    logic       term_b;
    logic       next_result;

    always_comb begin
        case (FLAG_SELECT)
            FSL_FIFO_PROG:  fifo_flag = TERMS.programmable_level_flag;
            FSL_FIFO_EMPTY: fifo_flag = TERMS.empty_flag;
            FSL_FIFO_FULL:  fifo_flag = TERMS.full_flag;
            default:        fifo_flag = TERMS.programmable_level_flag;
        endcase
    end

    always_comb begin
        term_vec[4:0] = TERMS.ready_in[4:0];
        term_vec[5]   = ready_configuration[TC_SEL_BIT]
                        ? TERMS.transaction_count_expired
                        : TERMS.ready_in[5];
        term_vec[6]   = fifo_flag;
        term_vec[7]   = ready_configuration[FW_READY_BIT];
        term_a        = term_vec[flow_function_select.first_term_select];
        term_b        = term_vec[flow_function_select.second_term_select];
    end

    always_comb begin
        case (flow_function_select.flow_function_code)
            FSL_FN_AND:      next_result = term_a & term_b;
            FSL_FN_OR:       next_result = term_a | term_b;
            FSL_FN_XOR:      next_result = term_a ^ term_b;
            FSL_FN_NOTA_AND: next_result = ~term_a & term_b;
            default:         next_result = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Flow state detection
    // ------------------------------------------------------------
    logic in_flow;
    logic flow_match;

    assign in_flow = WAVE_ACTIVE && flow_state_ctrl[FSE_BIT]
                     && (flow_state_ctrl[2:0] <= LAST_VALID_STATE)
                     && (WAVE_STATE == flow_state_ctrl[2:0]);
    // Polarity picks which result lets data move
    assign flow_match = (next_result == strobe_config[TOGGLE_POL_BIT]);

    // ------------------------------------------------------------
    // Control pin pattern and strobe gating
    // ------------------------------------------------------------
    fsl_ctl_drive_t flow_drive;
    logic [7:0]     sel_pattern;
    logic [5:0]     next_ctl_out;
    logic [5:0]     next_ctl_oe;
    logic [5:0]     strobe_mask;

    assign sel_pattern = next_result ? flow_one_ctl_pattern
                                     : flow_zero_ctl_pattern;

    fsl_ctl_drive u_drive (
        .pattern      (sel_pattern),
        .drive_config (control_drive_config),
        .drive        (flow_drive)
    );

    assign strobe_mask = (STROBE_SELECT < 3'h6) ? (6'h01 << STROBE_SELECT) : 6'h00;

    always_comb begin
        if (in_flow) begin
            next_ctl_out = flow_drive.value;
            next_ctl_oe  = flow_drive.enable;
            if (WAVE_MASTER && !flow_match) begin
                // Frozen strobe keeps its last level
                next_ctl_out = (flow_drive.value & ~strobe_mask)
                               | (CTL_OUT & strobe_mask);
            end
        end else begin
            next_ctl_out = WAVE_CTL;
            next_ctl_oe  = control_drive_config[TRISTATE_BIT] ? 6'h0f : 6'h3f;
        end
    end

    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            CTL_OUT      <= '0;
            CTL_OE       <= '0;
            FLOW_ACTIVE  <= 1'b0;
            FLOW_ADVANCE <= 1'b0;
            FLOW_RESULT  <= 1'b0;
        end else begin
            CTL_OUT      <= next_ctl_out;
            CTL_OE       <= next_ctl_oe;
            FLOW_ACTIVE  <= in_flow;
            // Only gates data; state exits stay with the engine
            FLOW_ADVANCE <= in_flow && flow_match;
            FLOW_RESULT  <= next_result;
        end
    end

    assign flow_status = {5'h00, in_flow, flow_match, next_result};
endmodule

// ### src/fsl_pkg.sv
// Package of constants and carrier types for the flow-state logic block
package fsl_pkg;

    // ------------------------------------------------------------
    // Register indices and byte addresses
    // ------------------------------------------------------------
    localparam logic [15:0] FLOW_FUNCTION_SELECT_IDX  = 16'he6c7;
    localparam logic [15:0] FLOW_ZERO_CTL_PATTERN_IDX = 16'he6c8;
    localparam logic [15:0] FLOW_ONE_CTL_PATTERN_IDX  = 16'he6c9;
    localparam logic [15:0] FLOW_STATE_CTRL_IDX       = 16'he6c6;
    localparam logic [15:0] CONTROL_DRIVE_CONFIG_IDX  = 16'he6ca;
    localparam logic [15:0] READY_CONFIGURATION_IDX   = 16'he6cb;
    localparam logic [15:0] STROBE_CONFIG_IDX         = 16'he6cc;
    localparam logic [15:0] FLOW_STATUS_IDX           = 16'he6cd;
    localparam int          ADDR_W                    = 18;
    localparam logic [ADDR_W-1:0] ADDR_FUNC   = {FLOW_FUNCTION_SELECT_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_EQ0    = {FLOW_ZERO_CTL_PATTERN_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_EQ1    = {FLOW_ONE_CTL_PATTERN_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_STATE  = {FLOW_STATE_CTRL_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_DRIVE  = {CONTROL_DRIVE_CONFIG_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_READY  = {READY_CONFIGURATION_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_STROBE = {STROBE_CONFIG_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_STATUS = {FLOW_STATUS_IDX, 2'b00};

    // ------------------------------------------------------------
    // Reset values and field positions
    // ------------------------------------------------------------
    localparam logic [7:0] RESET_FUNC   = 8'h00;
    localparam logic [7:0] RESET_EQ     = 8'h00;
    localparam logic [7:0] RESET_STATE  = 8'h00;
    localparam logic [7:0] RESET_DRIVE  = 8'h00;
    localparam logic [7:0] RESET_READY  = 8'h00;
    localparam logic [7:0] RESET_STROBE = 8'h20;
    localparam int FSE_BIT        = 7;
    localparam int TRISTATE_BIT   = 7;
    localparam int TC_SEL_BIT     = 5;
    localparam int FW_READY_BIT   = 7;
    localparam int TOGGLE_POL_BIT = 5;
    localparam logic [2:0] LAST_VALID_STATE = 3'h6;
    localparam int NUM_CTL  = 6;
    localparam int NUM_TRI  = 4;
    localparam int NUM_RDY  = 6;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // ------------------------------------------------------------
    // Enumerations and carrier types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        FSL_FN_AND     = 2'b00,
        FSL_FN_OR      = 2'b01,
        FSL_FN_XOR     = 2'b10,
        FSL_FN_NOTA_AND = 2'b11
    } fsl_func_t;

    typedef enum logic [1:0] {
        FSL_FIFO_PROG  = 2'b00,
        FSL_FIFO_EMPTY = 2'b01,
        FSL_FIFO_FULL  = 2'b10
    } fsl_flag_sel_t;

    typedef struct packed {
        fsl_func_t  flow_function_code;
        logic [2:0] first_term_select;
        logic [2:0] second_term_select;
    } fsl_func_reg_t;

    typedef struct packed {
        logic [NUM_RDY-1:0] ready_in;
        logic               transaction_count_expired;
        logic               programmable_level_flag;
        logic               empty_flag;
        logic               full_flag;
    } fsl_terms_t;

    typedef struct packed {
        logic [NUM_CTL-1:0] value;
        logic [NUM_CTL-1:0] enable;
    } fsl_ctl_drive_t;

    typedef struct packed {
        logic        awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [ADDR_W-1:0] araddr;
        logic        rready;
    } fsl_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } fsl_axi_rsp_t;

endpackage

// ### tb/fsl_bus_partner.sv
// Far-side bus partner: presents ready levels and sees the pin wires
`timescale 1ns/1ps
module fsl_bus_partner (
    input  wire logic       clk,       // Interface clock
    input  wire logic       rst_n,     // Async reset, active low
    input  wire logic       slow,      // Answer one cycle later
    input  wire logic [5:0] ready_set, // Ready levels to present
    input  wire logic [5:0] ctl_out,   // Pin values from the block
    input  wire logic [5:0] ctl_oe,    // Pin enables from the block
    output logic      [5:0] ctl_level, // Wire level at the pins
    output logic      [5:0] ready      // Ready pins towards the block
);
    // ------------------------------------------------------------
    // Pins and ready answer
    // ------------------------------------------------------------
    logic [5:0] ready_late;
    // Released pins float to the pull-up
    assign ctl_level = ctl_out | ~ctl_oe;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ready_late <= 6'h00;
            ready      <= 6'h00;
        end else begin
            ready_late <= ready_set;
            ready      <= slow ? ready_late : ready_set;
        end
    end
endmodule

// ### tb/fsl_flow_logic_assertions.sv
// Port-level checker for the flow-state logic block
`timescale 1ns/1ps
module fsl_flow_logic_assertions (
    input wire logic             CLK_SYS,       // Interface clock
    input wire logic             RSTN,          // Async reset, active low
    input fsl_pkg::fsl_axi_req_t AXI_REQ,       // Bus request
    input fsl_pkg::fsl_axi_rsp_t AXI_RSP,       // Bus response
    input wire logic [2:0]       WAVE_STATE,    // Waveform state
    input wire logic             WAVE_ACTIVE,   // Engine running
    input wire logic             WAVE_MASTER,   // Master mode
    input wire logic [5:0]       WAVE_CTL,      // Descriptor pattern
    input wire logic [2:0]       STROBE_SELECT, // Strobe pin index
    input wire logic [5:0]       CTL_OUT,       // Pin values
    input wire logic [5:0]       CTL_OE,        // Pin enables
    input wire logic             FLOW_ACTIVE,   // In flow state
    input wire logic             FLOW_ADVANCE   // Data may move
);
    import fsl_pkg::*;
    // ------------------------------------------------------------
    // Settling after reset and wire level
    // ------------------------------------------------------------
    logic [2:0] settle_cnt;
    wire  [5:0] level = CTL_OUT | ~CTL_OE;
    // Skip the reset synchroniser and the first output update
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            settle_cnt <= 3'h0;
        end else if (settle_cnt != 3'h4) begin
            settle_cnt <= settle_cnt + 3'h1;
        end
    end
    default clocking @(posedge CLK_SYS);
    endclocking
    default disable iff (settle_cnt != 3'h4);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    a_adv_needs_flow: assert property (FLOW_ADVANCE |-> FLOW_ACTIVE)
        else $error("advance seen outside the flow state");
    a_flow_gate: assert property (
        FLOW_ACTIVE |-> $past(WAVE_ACTIVE) && $past(WAVE_STATE) != 3'h7)
        else $error("flow state entered without a running engine");
    a_strobe_freeze: assert property (
        FLOW_ACTIVE && !FLOW_ADVANCE && $past(FLOW_ACTIVE) && $past(WAVE_MASTER)
        && $past(STROBE_SELECT) < 3'h6
        |-> (((CTL_OUT ^ $past(CTL_OUT)) >> $past(STROBE_SELECT)) & 6'h01) == 6'h00)
        else $error("master strobe moved while frozen");
    a_idle_pins: assert property (
        !FLOW_ACTIVE |-> level[3:0] == $past(WAVE_CTL[3:0]))
        else $error("pins do not follow the descriptor outside flow");
    a_read_answer: assert property (AXI_REQ.arvalid && AXI_RSP.arready |=> AXI_RSP.rvalid)
        else $error("read answer late");
    a_read_refused: assert property (AXI_RSP.rvalid |-> !AXI_RSP.arready)
        else $error("read address taken while answer pending");
    a_write_refused: assert property (AXI_RSP.bvalid |-> !AXI_RSP.awready && !AXI_RSP.wready)
        else $error("write taken while response pending");
    a_upper_zero: assert property (AXI_RSP.rvalid |-> AXI_RSP.rdata[31:8] == 24'h000000)
        else $error("upper read data bits not zero");
    c_advance: cover property (FLOW_ADVANCE);
    c_frozen: cover property (FLOW_ACTIVE && !FLOW_ADVANCE && WAVE_MASTER);
    c_read: cover property (AXI_RSP.rvalid && AXI_REQ.rready);
endmodule

// ### tb/fsl_flow_logic_test.sv
// Self-checking bench for the flow-state logic block
`timescale 1ns/1ps
module fsl_flow_logic_test;
    import fsl_pkg::*;
    typedef struct packed {
        logic [7:0] fn;
        logic [5:0] rdy;
        logic [3:0] misc;
        logic [1:0] fsel;
        logic [7:0] rcfg;
        logic       res;
    } fsl_row_t;
    // ------------------------------------------------------------
    // Signals and tables
    // ------------------------------------------------------------
    logic          clk_sys, rstn, slow, wave_master, flow_active, flow_advance, flow_result;
    logic [2:0]    wave_state;
    logic [5:0]    wave_ctl, rdy_set, rdy, ctl_out, ctl_oe, level;
    logic [3:0]    misc;
    logic [1:0]    rs;
    logic [31:0]   rd;
    logic [7:0]    pat;
    logic          wave_active = 1'b1;
    fsl_flag_sel_t fsel;
    fsl_terms_t    terms;
    fsl_axi_req_t  req;
    fsl_axi_rsp_t  rsp;
    int            n_errors = 0, n_checks = 0;
    fsl_row_t rows [13] = '{'{8'h01, 6'h03, 4'h0, 2'h0, 8'h00, 1'b1},
        '{8'h01, 6'h01, 4'h0, 2'h0, 8'h00, 1'b0}, '{8'h53, 6'h08, 4'h0, 2'h0, 8'h00, 1'b1},
        '{8'ha2, 6'h14, 4'h0, 2'h0, 8'h00, 1'b0}, '{8'ha2, 6'h10, 4'h0, 2'h0, 8'h00, 1'b1},
        '{8'hef, 6'h00, 4'h0, 2'h0, 8'h80, 1'b1}, '{8'hef, 6'h20, 4'h0, 2'h0, 8'h80, 1'b0},
        '{8'hef, 6'h20, 4'h0, 2'h0, 8'ha0, 1'b1}, '{8'h36, 6'h00, 4'h1, 2'h2, 8'h00, 1'b1},
        '{8'h36, 6'h00, 4'h1, 2'h1, 8'h00, 1'b0}, '{8'h70, 6'h00, 4'h4, 2'h0, 8'h00, 1'b1},
        '{8'h70, 6'h00, 4'hb, 2'h3, 8'h00, 1'b0}, '{8'h07, 6'h01, 4'h0, 2'h0, 8'h00, 1'b0}};
    logic [17:0] raddr [5] = '{ADDR_FUNC, ADDR_EQ0, ADDR_EQ1, ADDR_STROBE, 18'h00010};
    logic [9:0]  rexp [5] = '{{RESP_OKAY, RESET_FUNC}, {RESP_OKAY, RESET_EQ},
        {RESP_OKAY, RESET_EQ}, {RESP_OKAY, RESET_STROBE}, {RESP_SLVERR, 8'h00}};
    logic [31:0] dcfg [2] = '{32'h805a053a, 32'h3f152a15};
    logic [15:0] gate [5] = '{16'h8320, 16'h8770, 16'h0330, 16'h8338, 16'h8331};
    assign terms = {rdy, misc};
    fsl_flow_logic dut (.CLK_SYS(clk_sys), .RSTN(rstn), .AXI_REQ(req), .AXI_RSP(rsp),
        .WAVE_STATE(wave_state), .WAVE_ACTIVE(wave_active), .WAVE_MASTER(wave_master),
        .WAVE_CTL(wave_ctl), .STROBE_SELECT(3'h0), .TERMS(terms), .FLAG_SELECT(fsel),
        .CTL_OUT(ctl_out), .CTL_OE(ctl_oe), .FLOW_ACTIVE(flow_active),
        .FLOW_ADVANCE(flow_advance), .FLOW_RESULT(flow_result));
    fsl_bus_partner u_partner (.clk(clk_sys), .rst_n(rstn), .slow(slow), .ready_set(rdy_set),
        .ctl_out(ctl_out), .ctl_oe(ctl_oe), .ctl_level(level), .ready(rdy));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic give_verdict();
        if (n_errors == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic axi_xfer(input logic wr, input logic [17:0] a, input logic [7:0] d,
                            output logic [1:0] r, output logic [31:0] q);
        logic aw, w, ar, done = 1'b0;
        @(posedge clk_sys);
        req <= '{wr, a, wr, {24'h000000, d}, 4'hf, wr, !wr, a, !wr};
        while (!done) begin
            @(negedge clk_sys);
            done = wr ? rsp.bvalid : rsp.rvalid;
            r = wr ? rsp.bresp : rsp.rresp;
            q = rsp.rdata;
            aw = rsp.awready;
            w = rsp.wready;
            ar = rsp.arready;
            @(posedge clk_sys);
            if (aw) req.awvalid <= 1'b0;
            if (w) req.wvalid <= 1'b0;
            if (ar) req.arvalid <= 1'b0;
        end
        req.bready <= 1'b0;
        req.rready <= 1'b0;
    endtask
    task automatic wr(input logic [17:0] a, input logic [7:0] d);
        axi_xfer(1'b1, a, d, rs, rd);
        check("bresp", 32'(RESP_OKAY), 32'(rs));
    endtask
    task automatic settle();
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask
    // ------------------------------------------------------------
    // Clock, watchdog and sequence
    // ------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (30000) @(posedge clk_sys);
        n_errors++;
        give_verdict();
    end
    initial begin
        rstn = 1'b0;
        req = '0;
        slow = 1'b0;
        wave_master = 1'b0;
        wave_state = 3'h3;
        wave_ctl = 6'h2b;
        rdy_set = 6'h00;
        misc = 4'h0;
        fsel = FSL_FIFO_PROG;
        repeat (16) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        for (int i = 0; i < 5; i++) begin
            axi_xfer(1'b0, raddr[i], 8'h00, rs, rd);
            check("rdata", 32'(rexp[i][7:0]), rd);
            check("rresp", 32'(rexp[i][9:8]), 32'(rs));
        end
        axi_xfer(1'b1, 18'h00010, 8'h55, rs, rd);
        check("unmapped bresp", 32'(RESP_SLVERR), 32'(rs));
        wr(ADDR_STATE, 8'h83);
        wr(ADDR_EQ0, 8'h0a);
        wr(ADDR_EQ1, 8'h35);
        axi_xfer(1'b0, ADDR_EQ1, 8'h00, rs, rd);
        check("readback", 32'h00000035, rd);
        foreach (rows[i]) begin
            wr(ADDR_FUNC, rows[i].fn);
            wr(ADDR_READY, rows[i].rcfg);
            rdy_set <= rows[i].rdy;
            misc <= rows[i].misc;
            fsel <= fsl_flag_sel_t'(rows[i].fsel);
            slow <= i[0];
            settle();
            pat = rows[i].res ? 8'h35 : 8'h0a;
            check("result", 32'(rows[i].res), 32'(flow_result));
            check("advance", 32'(rows[i].res), 32'(flow_advance));
            check("pins", {20'h0, 6'h3f, pat[5:0]}, {20'h0, ctl_oe, ctl_out});
        end
        wr(ADDR_STROBE, 8'h00);
        settle();
        check("inverted advance", 32'h1, 32'(flow_advance));
        wr(ADDR_STROBE, 8'h20);
        wave_master <= 1'b1;
        wr(ADDR_READY, 8'h80);
        settle();
        check("strobe high", 32'h1, 32'(ctl_out[0]));
        wr(ADDR_READY, 8'h00);
        settle();
        check("strobe frozen", 32'h0b, 32'(ctl_out));
        @(posedge clk_sys);
        wave_master <= 1'b0;
        for (int i = 0; i < 2; i++) begin
            wr(ADDR_DRIVE, dcfg[i][31:24]);
            wr(ADDR_EQ0, dcfg[i][23:16]);
            settle();
            check("pin enables", 32'(dcfg[i][15:8]), 32'(ctl_oe));
            check("pin levels", 32'(dcfg[i][7:0]), 32'(level));
        end
        wr(ADDR_DRIVE, 8'h00);
        for (int i = 0; i < 5; i++) begin
            wr(ADDR_STATE, gate[i][15:8]);
            wave_state <= gate[i][6:4];
            wave_active <= !gate[i][3];
            settle();
            check("flow active", 32'(gate[i][0]), 32'(flow_active));
            check("gate levels", gate[i][0] ? 32'h15 : 32'h2b, 32'(level));
        end
        axi_xfer(1'b0, ADDR_STATUS, 8'h00, rs, rd);
        check("status", 32'h00000004, rd);
        give_verdict();
    end
endmodule
bind fsl_flow_logic fsl_flow_logic_assertions u_chk (.CLK_SYS(CLK_SYS), .RSTN(RSTN),
    .AXI_REQ(AXI_REQ), .AXI_RSP(AXI_RSP), .WAVE_STATE(WAVE_STATE),
    .WAVE_ACTIVE(WAVE_ACTIVE), .WAVE_MASTER(WAVE_MASTER), .WAVE_CTL(WAVE_CTL),
    .STROBE_SELECT(STROBE_SELECT), .CTL_OUT(CTL_OUT), .CTL_OE(CTL_OE),
    .FLOW_ACTIVE(FLOW_ACTIVE), .FLOW_ADVANCE(FLOW_ADVANCE));
